// >>> shared/fpg_defs.svh
`ifndef FPG_DEFS_SVH
`define FPG_DEFS_SVH

// =====================================================================
// register word indices (byte address = index * 4)
`define FPG_IDX_MODE    6'h00
`define FPG_IDX_BLK_ONE 6'h01
`define FPG_IDX_BLK_TWO 6'h02
`define FPG_IDX_RAM_CTL 6'h03
`define FPG_IDX_STATUS  6'h04

// =====================================================================
// flash mode control fields
`define FPG_BIT_P       0
`define FPG_BIT_E       1
`define FPG_BIT_PCHK    2
`define FPG_BIT_WCHK    3
`define FPG_BIT_VPP     7
`define FPG_RST_MODE    4'h0
`define FPG_RST_EBR     8'h00

// =====================================================================
// ram control fields
`define FPG_BIT_RAME    7
`define FPG_BIT_RSV5    5
`define FPG_BIT_ERR     4
`define FPG_BIT_OVSEL   3
`define FPG_RST_RAME    1'b1
`define FPG_RST_OVL     4'h0

// =====================================================================
// timing
`define FPG_CLK_NS      8
`define FPG_PWV_NS      2000
`define FPG_PWV_CYC     ((`FPG_PWV_NS + `FPG_CLK_NS - 1) / `FPG_CLK_NS)

`endif

// >>> shared/fpg_pkg.sv
package fpg_pkg;
    typedef enum logic {FPG_BUS_IDLE, FPG_BUS_READ} fpg_bus_e;
    typedef logic [7:0]  fpg_byte_t;
    typedef logic [15:0] fpg_blk_t;
endpackage

// >>> shared/fpg_ctl_if.sv
`timescale 1ns/10ps
// register state in, gated array controls out
interface fpg_ctl_if;
    logic              p_bit;
    logic              e_bit;
    logic              pchk_bit;
    logic              wchk_bit;
    fpg_pkg::fpg_blk_t ebr;
    logic              ovsel;
    logic              err;
    logic              vpp;
    logic              prog;
    logic              erase;
    fpg_pkg::fpg_blk_t blk;
    logic              pvm;
    logic              evm;
    logic              pwv;
    modport ctl  (output p_bit, e_bit, pchk_bit, wchk_bit, ebr, ovsel, err, vpp,
                  input prog, erase, blk, pvm, evm, pwv);
    modport gate (input p_bit, e_bit, pchk_bit, wchk_bit, ebr, ovsel, err, vpp,
                  output prog, erase, blk, pvm, evm, pwv);
endinterface

// >>> verilog/fpg_gate.sv
`timescale 1ns/10ps
// =====================================================================
// protection gating of mode bits into array controls
module fpg_gate (
    fpg_ctl_if.gate c
);
    import fpg_pkg::*;

    logic no_write;

    always_comb begin
        // emulation, error and supply-absent protection
        no_write = c.ovsel | c.err | ~c.vpp;
        c.prog   = c.p_bit & ~no_write;
        // empty block selects protect every block
        c.erase  = c.e_bit & ~no_write & (|c.ebr);
        // protected erase never names single blocks
        c.blk    = c.erase ? c.ebr : '0;
        // verify stays usable under error and emulation protect
        c.pvm    = c.pchk_bit & c.vpp;
        c.evm    = c.wchk_bit & c.vpp;
        c.pwv    = c.vpp & ~(c.p_bit | c.e_bit | c.pchk_bit | c.wchk_bit);
    end
endmodule

// >>> verilog/fpg_top.sv
// Functional notes
// - all mode bits clear with supply present selects prewrite verify
// - block selects gate erase only; zero protects
// - overlay select blocks program and erase
// - supply absent clears mode and block selects
// - reset or standby clears mode and selects
// - error aborts operation, registers keep values
// - error protect only while program/erase set
// - under error, bits writable, no operation
// - verify bits work in error protect
// - only reset or hardware standby clear error
// - registers writable; software standby clears them
// - error protect touches flash operations only
// - nmi masked while program or erase set
// - nmi masked in boot until ram branch
// - reads during program/erase return undetermined data
// - protected erase covers all blocks together
// - enable set and low bits cleared by hard reset
// - overlay bits writable only user/boot mode
`timescale 1ns/10ps
`include "fpg_defs.svh"

module fpg_top (
    input  wire logic              hclk,
    input  wire logic              hresetn,
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic      [31:0]       hrdata,
    output logic                   hreadyout,
    output logic                   hresp,
    input  wire logic              vpp_present,
    input  wire logic              hw_standby,
    input  wire logic              sw_standby,
    input  wire logic              wdt_reset,
    input  wire logic              user_or_boot_mode,
    input  wire logic              boot_mode,
    input  wire logic              boot_ram_branch,
    input  wire logic              flash_error_detect,
    input  wire logic              nmi_in,
    output logic                   nmi_out,
    output logic                   prog_en,
    output logic                   erase_en,
    output fpg_pkg::fpg_blk_t      blk_erase_en,
    output logic                   prog_verify_en,
    output logic                   erase_verify_en,
    output logic                   prewrite_verify_en,
    output logic                   read_data_invalid
);
    import fpg_pkg::*;

    // =================================================================
    // state
    logic [3:0]      mode_q;
    fpg_byte_t       blk_one_q;
    fpg_byte_t       blk_two_q;
    logic            ram_en_q;
    logic [3:0]      ovl_q;
    logic            err_q;
    logic            started_q;
    logic            boot_run_q;
    logic [7:0]      settle_cnt_q;
    logic            settled_q;
    fpg_bus_e        bus_q;
    logic            wr_pend_q;
    logic [5:0]      wr_idx_q;
    logic [5:0]      rd_idx_q;
    logic [31:0]     hrdata_q;
    logic            hreadyout_q;
    logic            nmi_q;
    logic            prog_q;
    logic            erase_q;
    fpg_blk_t        blk_q;
    logic            pvm_q;
    logic            evm_q;
    logic            pwv_q;
    logic            rdinv_q;

    logic            flash_init;
    logic            hard_clear;
    logic            addr_phase;
    logic            pe_set;
    logic            nmi_mask;
    logic [31:0]     rd_mux;

    fpg_ctl_if       ctl ();

    // =================================================================
    // clear conditions
    assign hard_clear = hw_standby | wdt_reset;
    assign flash_init = ~vpp_present | hw_standby | sw_standby | wdt_reset;
    assign pe_set     = mode_q[`FPG_BIT_P] | mode_q[`FPG_BIT_E];
    assign addr_phase = hsel & htrans[1] & hready;

    // =================================================================
    // word read decode, shared by the read path
    function automatic logic [31:0] reg_read(
        input logic [5:0] idx
    );
        logic [7:0] v;
        v = 8'h00;
        unique case (idx)
            `FPG_IDX_MODE: begin
                v                = {4'h0, mode_q};
                v[`FPG_BIT_VPP]  = vpp_present;
            end
            `FPG_IDX_BLK_ONE: begin
                v = blk_one_q;
            end
            `FPG_IDX_BLK_TWO: begin
                v = blk_two_q;
            end
            `FPG_IDX_RAM_CTL: begin
                // overlay field reads zero outside user and boot mode
                v[3:0]           = user_or_boot_mode ? ovl_q : 4'h0;
                v[`FPG_BIT_ERR]  = err_q;
                v[`FPG_BIT_RSV5] = 1'b1;
                v[`FPG_BIT_RAME] = ram_en_q;
            end
            `FPG_IDX_STATUS: begin
                v = {boot_run_q, settled_q, err_q, nmi_mask,
                     pwv_q, pvm_q | evm_q, erase_q, prog_q};
            end
            default: begin
                v = 8'h00;
            end
        endcase
        return {24'h000000, v};
    endfunction

    // always_comb so the mux follows register changes, not only the index
    always_comb begin
        rd_mux = reg_read(rd_idx_q);
    end

    // =================================================================
    // flash mode control register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_q <= `FPG_RST_MODE;
        end else if (flash_init) begin
            mode_q <= `FPG_RST_MODE;
        end else if (wr_pend_q && wr_idx_q == `FPG_IDX_MODE) begin
            // writable even in error protect; gating happens downstream
            mode_q <= hwdata[3:0];
        end
    end

    // =================================================================
    // erase block select registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            blk_one_q <= `FPG_RST_EBR;
            blk_two_q <= `FPG_RST_EBR;
        end else if (flash_init) begin
            blk_one_q <= `FPG_RST_EBR;
            blk_two_q <= `FPG_RST_EBR;
        end else if (wr_pend_q) begin
            if (wr_idx_q == `FPG_IDX_BLK_ONE) begin
                blk_one_q <= hwdata[7:0];
            end
            if (wr_idx_q == `FPG_IDX_BLK_TWO) begin
                blk_two_q <= hwdata[7:0];
            end
        end
    end

    // =================================================================
    // ram control enable and overlay field
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ram_en_q <= `FPG_RST_RAME;
        end else if (hard_clear) begin
            ram_en_q <= `FPG_RST_RAME;
        end else if (wr_pend_q && wr_idx_q == `FPG_IDX_RAM_CTL) begin
            ram_en_q <= hwdata[`FPG_BIT_RAME];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ovl_q <= `FPG_RST_OVL;
        end else if (hard_clear || !vpp_present) begin
            ovl_q <= `FPG_RST_OVL;
        end else if (wr_pend_q && wr_idx_q == `FPG_IDX_RAM_CTL
                     && user_or_boot_mode) begin
            ovl_q <= hwdata[3:0];
        end
    end

    // =================================================================
    // error flag: set only while program or erase bit is set
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            err_q <= 1'b0;
        end else if (flash_error_detect && pe_set) begin
            err_q <= 1'b1;
        end else if (hard_clear) begin
            err_q <= 1'b0;
        end
    end

    // =================================================================
    // boot strap capture and boot-time nmi masking
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            started_q  <= 1'b0;
            boot_run_q <= 1'b0;
        end else if (!started_q) begin
            started_q  <= 1'b1;
            boot_run_q <= boot_mode;
        end else if (boot_ram_branch) begin
            boot_run_q <= 1'b0;
        end
    end

    assign nmi_mask = pe_set | boot_run_q | ~started_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            nmi_q <= 1'b0;
        end else begin
            nmi_q <= nmi_in & ~nmi_mask;
        end
    end

    // =================================================================
    // prewrite verify settling indicator
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            settle_cnt_q <= 8'h00;
            settled_q    <= 1'b0;
        end else if (!ctl.pwv) begin
            settle_cnt_q <= 8'h00;
            settled_q    <= 1'b0;
        end else if (settle_cnt_q == 8'(`FPG_PWV_CYC - 1)) begin
            settled_q    <= 1'b1;
        end else begin
            settle_cnt_q <= settle_cnt_q + 8'h01;
        end
    end

    // =================================================================
    // protection gating
    assign ctl.p_bit    = mode_q[`FPG_BIT_P];
    assign ctl.e_bit    = mode_q[`FPG_BIT_E];
    assign ctl.pchk_bit = mode_q[`FPG_BIT_PCHK];
    assign ctl.wchk_bit = mode_q[`FPG_BIT_WCHK];
    assign ctl.ebr      = {blk_two_q, blk_one_q};
    assign ctl.ovsel    = ovl_q[`FPG_BIT_OVSEL];
    assign ctl.err      = err_q;
    assign ctl.vpp      = vpp_present;

    fpg_gate u_gate (
        .c (ctl.gate)
    );

    // =================================================================
    // registered array controls
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prog_q  <= 1'b0;
            erase_q <= 1'b0;
            blk_q   <= '0;
            pvm_q   <= 1'b0;
            evm_q   <= 1'b0;
            pwv_q   <= 1'b0;
            rdinv_q <= 1'b0;
        end else begin
            prog_q  <= ctl.prog;
            erase_q <= ctl.erase;
            blk_q   <= ctl.blk;
            pvm_q   <= ctl.pvm;
            evm_q   <= ctl.evm;
            pwv_q   <= ctl.pwv;
            rdinv_q <= pe_set;
        end
    end

    // =================================================================
    // ahb-lite slave: writes zero wait, reads one wait
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_idx_q  <= 6'h00;
        end else begin
            wr_pend_q <= addr_phase & hwrite;
            if (addr_phase && hwrite) begin
                wr_idx_q <= haddr[7:2];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bus_q       <= FPG_BUS_IDLE;
            rd_idx_q    <= 6'h00;
            hreadyout_q <= 1'b1;
            hrdata_q    <= 32'h00000000;
        end else begin
            unique case (bus_q)
                FPG_BUS_IDLE: begin
                    if (addr_phase && !hwrite) begin
                        bus_q       <= FPG_BUS_READ;
                        rd_idx_q    <= haddr[7:2];
                        hreadyout_q <= 1'b0;
                    end
                end
                FPG_BUS_READ: begin
                    bus_q       <= FPG_BUS_IDLE;
                    hrdata_q    <= rd_mux;
                    hreadyout_q <= 1'b1;
                end
            endcase
        end
    end

    // =================================================================
    // outputs
    assign hrdata             = hrdata_q;
    assign hreadyout          = hreadyout_q;
    assign hresp              = 1'b0;
    assign nmi_out            = nmi_q;
    assign prog_en            = prog_q;
    assign erase_en           = erase_q;
    assign blk_erase_en       = blk_q;
    assign prog_verify_en     = pvm_q;
    assign erase_verify_en    = evm_q;
    assign prewrite_verify_en = pwv_q;
    assign read_data_invalid  = rdinv_q;

endmodule

// >>> sim/fpg_gate_monitor.sv
`timescale 1ns/10ps
module fpg_gate_monitor (
    input wire logic              hclk,
    input wire logic              hresetn,
    input wire logic              vpp_present,
    input wire logic              hw_standby,
    input wire logic              sw_standby,
    input wire logic              wdt_reset,
    input wire logic              flash_error_detect,
    input wire logic              nmi_in,
    input wire logic              nmi_out,
    input wire logic              prog_en,
    input wire logic              erase_en,
    input wire fpg_pkg::fpg_blk_t blk_erase_en,
    input wire logic              prog_verify_en,
    input wire logic              erase_verify_en,
    input wire logic              prewrite_verify_en,
    input wire logic              read_data_invalid
);
    import fpg_pkg::*;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // =================================================================
    // protection gating
    chk_supply_clears: assert property (!vpp_present |=> !prog_en && !erase_en && !prewrite_verify_en)
        else $error("enables held without supply");
    chk_verify_supply: assert property ((prog_verify_en || erase_verify_en) |-> $past(vpp_present))
        else $error("verify without supply");
    chk_standby_clears: assert property ((sw_standby || hw_standby || wdt_reset) |-> ##2
        (!prog_en && !erase_en && !prog_verify_en && !erase_verify_en))
        else $error("modes survived standby or reset");
    chk_prewrite_alone: assert property (prewrite_verify_en |->
        !prog_en && !erase_en && !prog_verify_en && !erase_verify_en)
        else $error("prewrite verify overlaps another mode");
    chk_block_gate: assert property (erase_en == (blk_erase_en != 16'h0000))
        else $error("block erase enables disagree with erase mode");
    chk_error_abort: assert property (flash_error_detect && prog_en |-> ##2 (!prog_en && !erase_en))
        else $error("operation not aborted on error");
    chk_read_invalid: assert property ((prog_en || erase_en) |-> read_data_invalid)
        else $error("reads marked valid during operation");

    // =================================================================
    // nmi masking
    chk_nmi_masked: assert property (read_data_invalid && $past(read_data_invalid) |-> !nmi_out)
        else $error("nmi passed while program or erase set");
    chk_nmi_source: assert property (nmi_out |-> $past(nmi_in))
        else $error("nmi raised without request");
endmodule

bind fpg_top fpg_gate_monitor mon (.hclk, .hresetn, .vpp_present, .hw_standby, .sw_standby, .wdt_reset,
    .flash_error_detect, .nmi_in, .nmi_out, .prog_en, .erase_en, .blk_erase_en, .prog_verify_en,
    .erase_verify_en, .prewrite_verify_en, .read_data_invalid);

// >>> sim/fpg_flash_model.sv
`timescale 1ns/10ps
// error-detect source: one-cycle pulse a chosen number of cycles after a request
module fpg_flash_model (
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic       inject,
    input  wire logic [3:0] lag,
    output logic            err_pulse
);
    logic [4:0] cnt_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_q     <= 5'h00;
            err_pulse <= 1'b0;
        end else begin
            err_pulse <= (cnt_q == 5'h01);
            if (inject) begin
                cnt_q <= {1'b0, lag} + 5'h01;
            end else if (cnt_q != 5'h00) begin
                cnt_q <= cnt_q - 5'h01;
            end
        end
    end
endmodule

// >>> sim/flash_protect_nmi_gating_bench.sv
`timescale 1ns/10ps
`define FPG_CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin bad_count++; \
    $display("unexpected at %0t got %h expected %h", $time, (a), (e)); end end
module flash_protect_nmi_gating_bench;
    import fpg_pkg::*;
    logic        hclk, hresetn, hsel, hwrite, vpp_present, user_or_boot_mode, boot_mode, nmi_in;
    logic [31:0] haddr, hwdata, q;
    logic [1:0]  htrans;
    logic [4:0]  pls;
    logic [3:0]  lag;
    wire  [31:0] hrdata;
    wire         hreadyout, hresp, flash_error_detect, nmi_out, prog_en, erase_en;
    wire         prog_verify_en, erase_verify_en, prewrite_verify_en, read_data_invalid;
    wire  fpg_blk_t blk_erase_en;
    int          bad_count, samples_checked;

    fpg_top uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout),
        .hrdata, .hreadyout, .hresp, .vpp_present, .hw_standby(pls[0]), .sw_standby(pls[1]), .wdt_reset(pls[2]),
        .user_or_boot_mode, .boot_mode, .boot_ram_branch(pls[3]), .flash_error_detect, .nmi_in, .nmi_out,
        .prog_en, .erase_en, .blk_erase_en, .prog_verify_en, .erase_verify_en, .prewrite_verify_en,
        .read_data_invalid);
    fpg_flash_model arr (.hclk, .hresetn, .inject(pls[4]), .lag, .err_pulse(flash_error_detect));

    initial begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end

    // =================================================================
    // access tasks
    task automatic tick(input int n);
        repeat (n) @(posedge hclk);
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel   <= 1'b1;
        haddr  <= {24'h000000, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h00000000);
        `FPG_CHK(q, e)
    endtask
    // order: prog erase progchk erasechk prewrite invalid nmi
    task automatic pin(input logic [6:0] e);
        tick(3);
        `FPG_CHK({prog_en, erase_en, prog_verify_en, erase_verify_en, prewrite_verify_en, read_data_invalid,
                  nmi_out}, e)
    endtask
    task automatic pulse(input logic [4:0] m);
        pls <= m;
        tick(1);
        pls <= 5'h00;
        tick(1);
    endtask
    task automatic summarize();
        $display("compares %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        tick(5000);
        bad_count++;
        summarize();
    end

    // =================================================================
    // scenarios
    initial begin
        hresetn = 1'b0;
        {hsel, hwrite, nmi_in, user_or_boot_mode, boot_mode} = 5'h00;
        {haddr, hwdata} = 64'h0;
        htrans = 2'h0;
        pls = 5'h00;
        lag = 4'h0;
        vpp_present = 1'b1;
        tick(12);
        hresetn <= 1'b1;
        tick(1);
        rdc(8'h00, 32'h00000080);
        rdc(8'h04, 32'h00000000);
        rdc(8'h0C, 32'h000000A0);
        pin(7'b0000100);
        tick(250);
        bus(1'b0, 8'h10, 32'h0);
        `FPG_CHK(q[6], 1'b1)
        nmi_in <= 1'b1;
        bus(1'b1, 8'h00, 32'h1);
        pin(7'b1000010);
        bus(1'b1, 8'h00, 32'h0);
        bus(1'b1, 8'h00, 32'h2);
        pin(7'b0000010);
        bus(1'b1, 8'h04, 32'h05);
        bus(1'b1, 8'h08, 32'h80);
        pin(7'b0100010);
        `FPG_CHK(blk_erase_en, 16'h8005)
        bus(1'b1, 8'h0C, 32'h88);
        rdc(8'h0C, 32'h000000A0);
        user_or_boot_mode <= 1'b1;
        rdc(8'h0C, 32'h000000A0);
        bus(1'b1, 8'h0C, 32'h88);
        rdc(8'h0C, 32'h000000A8);
        bus(1'b1, 8'h00, 32'h7);
        pin(7'b0010010);
        bus(1'b1, 8'h0C, 32'h80);
        pin(7'b1110010);
        bus(1'b1, 8'h00, 32'h0);
        pin(7'b0000101);
        pulse(5'h10);
        tick(3);
        rdc(8'h0C, 32'h000000A0);
        bus(1'b1, 8'h00, 32'h1);
        lag <= 4'h5;
        pulse(5'h10);
        tick(8);
        pin(7'b0000010);
        rdc(8'h00, 32'h00000081);
        rdc(8'h0C, 32'h000000B0);
        bus(1'b1, 8'h00, 32'h0);
        bus(1'b1, 8'h00, 32'h3);
        rdc(8'h00, 32'h00000083);
        pin(7'b0000010);
        `FPG_CHK(blk_erase_en, 16'h0000)
        bus(1'b1, 8'h00, 32'hC);
        pin(7'b0011001);
        bus(1'b1, 8'h04, 32'h11);
        rdc(8'h04, 32'h00000011);
        pulse(5'h02);
        rdc(8'h00, 32'h00000080);
        rdc(8'h04, 32'h00000000);
        rdc(8'h0C, 32'h000000B0);
        bus(1'b1, 8'h0C, 32'h80);
        rdc(8'h0C, 32'h000000B0);
        pulse(5'h01);
        rdc(8'h0C, 32'h000000A0);
        bus(1'b1, 8'h00, 32'h1);
        bus(1'b1, 8'h04, 32'h1);
        vpp_present <= 1'b0;
        tick(2);
        pin(7'b0000001);
        rdc(8'h00, 32'h00000000);
        rdc(8'h04, 32'h00000000);
        vpp_present <= 1'b1;
        bus(1'b1, 8'h00, 32'h1);
        pulse(5'h04);
        rdc(8'h00, 32'h00000080);
        bus(1'b1, 8'h20, 32'hFF);
        rdc(8'h20, 32'h00000000);
        `FPG_CHK(hresp, 1'b0)
        `FPG_CHK(hreadyout, 1'b1)
        boot_mode <= 1'b1;
        hresetn <= 1'b0;
        tick(6);
        hresetn <= 1'b1;
        tick(2);
        boot_mode <= 1'b0;
        pin(7'b0000100);
        pulse(5'h08);
        pin(7'b0000101);
        summarize();
    end
endmodule
